// ===== core/tfc_pkg.sv
// Package for the trace capture and readout block of the on-chip debug module.
// Assumes a 10 MHz core clock and a plain register port with 8-bit data.
package tfc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register offsets on the plain register port.
    localparam logic [3:0] TFC_OFF_CONTROL = 4'h0;
    localparam logic [3:0] TFC_OFF_TRIGGER = 4'h1;
    localparam logic [3:0] TFC_OFF_STATUS = 4'h2;
    localparam logic [3:0] TFC_OFF_COUNT = 4'h3;
    localparam logic [3:0] TFC_OFF_TRACE_HIGH = 4'h4;
    localparam logic [3:0] TFC_OFF_TRACE_LOW = 4'h5;
    localparam logic [3:0] TFC_OFF_CMPA_EXT = 4'h6;
    localparam logic [3:0] TFC_OFF_CMPA_HIGH = 4'h7;
    localparam logic [3:0] TFC_OFF_CMPA_LOW = 4'h8;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions.
    localparam int TFC_CTL_ENABLE = 7;
    localparam int TFC_CTL_ARM = 6;
    localparam int TFC_CTL_TAG = 5;
    localparam int TFC_CTL_BREAK = 4;
    localparam int TFC_TRG_OPCODE = 7;
    localparam int TFC_TRG_BEGIN = 6;
    localparam int TFC_STS_MATCH_A = 7;
    localparam int TFC_STS_MATCH_B = 6;
    localparam int TFC_STS_MATCH_C = 5;
    localparam int TFC_STS_ARMED = 0;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values and fixed figures.
    localparam logic [7:0] TFC_RST_CONTROL = 8'hc0;
    localparam logic [7:0] TFC_RST_TRIGGER = 8'h40;
    localparam logic [7:0] TFC_RST_STATUS = 8'h01;
    localparam logic [7:0] TFC_RST_CMPA_EXT = 8'h00;
    localparam logic [7:0] TFC_RST_CMPA_HIGH = 8'hff;
    localparam logic [7:0] TFC_RST_CMPA_LOW = 8'hfe;
    localparam logic [7:0] TFC_EVENT_HIGH = 8'h00;
    localparam logic [15:0] TFC_BRANCH_BACKSTEP = 16'h0002;
    localparam int TFC_DEPTH = 8;
    localparam logic [3:0] TFC_FULL_COUNT = 4'h8;

    ////////////////////////////////////////////////////////////////////////////
    // Carriers.
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } tfc_bus_t;

    typedef struct packed {
        logic [1:0] cof;
        logic [15:0] addr;
        logic [7:0] data;
        logic [15:0] opcodeAddr;
        logic intPending;
    } tfc_core_t;

    typedef struct packed {
        logic triggerHit;
        logic eventOnlyMode;
        logic matchA;
        logic matchB;
        logic matchC;
    } tfc_trig_t;

    typedef struct packed {
        logic [7:0] ext;
        logic [7:0] high;
        logic [7:0] low;
    } tfc_cmpa_t;

    typedef struct packed {
        logic [TFC_DEPTH-1:0][15:0] mem;
        logic [2:0] wrPtr;
        logic [2:0] rdPtr;
        logic [3:0] validCount;
        logic [7:0] control;
        logic [7:0] trigger;
        logic [7:0] status;
        tfc_cmpa_t cmpA;
        logic [15:0] prevAddr;
        logic triggered;
        logic breakReq;
        logic [7:0] readData;
    } tfc_state_t;

endpackage

// ===== core/tfc_trace_capture.sv
// Trace capture and readout: an eight-word trace store filled from core
// change-of-flow events under begin or end trigger, read over a register port.
// Assumes comparators and trigger-mode decoding sit outside and drive trig.
//
// Functional notes
// - Trace store holds up to eight words.
// - Event-only modes store data, high byte zero.
// - Destination change-of-flow stores current core address.
// - Taken branch stores previous address minus two.
// - Begin mode waits for trigger, stores eight.
// - End mode stores until trigger, then disarms.
// - End trigger on change-of-flow is stored.
// - Store readable only when enabled, armed or not.
// - Oldest first; count does not decrement.
// - Optional high read, low read advances.
// - Armed read returns oldest, no shift.
// - Unarmed low read captures opcode address.
// - Opcode trigger lost to coincident pending interrupt.
// - Address end trigger skips interrupt change-of-flow.
// - Address begin trigger captures interrupt change-of-flow.
// - Module never requests a system reset.
// - Non-power-on reset in end run keeps trace results.
// - Other resets load comparator A with 0x00FFFE.
// - Other resets load control with 0xc0.
// - Other resets load trigger with 0x40.
// - Disarm on end trigger or full store.
// - Arming clears A, B and C flags.
`timescale 1ns/10ps

module tfc_trace_capture (
    input wire logic clk,
    input wire logic rst,
    input wire logic powerOnReset,
    input wire tfc_pkg::tfc_bus_t bus,
    output logic [7:0] readData,
    input wire tfc_pkg::tfc_core_t core,
    input wire tfc_pkg::tfc_trig_t trig,
    output tfc_pkg::tfc_cmpa_t cmpA,
    output logic [7:0] triggerReg,
    output logic [7:0] controlReg,
    output logic armed,
    output logic breakRequest
);

    ////////////////////////////////////////////////////////////////////////////
    // Helpers.

    // Next slot of the circular store.
    function automatic logic [2:0] tfc_ptr_next(input logic [2:0] ptr);
        tfc_ptr_next = ptr + 3'h1;
    endfunction

    // Byte of the oldest entry: high half or low half.
    function automatic logic [7:0] tfc_oldest_byte(input tfc_pkg::tfc_state_t s, input logic high);
        logic [15:0] word;
        word = s.mem[s.rdPtr];
        tfc_oldest_byte = high ? word[15:8] : word[7:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State.
    tfc_pkg::tfc_state_t st;
    tfc_pkg::tfc_state_t next_st;

    logic enabled;
    logic armBit;
    logic armedNow;
    logic beginType;
    logic trigQualified;
    logic doStore;
    logic disarmNow;
    logic [15:0] storeWord;
    logic [15:0] cofAddr;

    // Decode of the run type and the qualified trigger.
    always_comb begin
        enabled = st.control[tfc_pkg::TFC_CTL_ENABLE];
        armBit = st.control[tfc_pkg::TFC_CTL_ARM];
        armedNow = enabled && armBit && st.status[tfc_pkg::TFC_STS_ARMED];
        // Event-only modes always behave as begin runs.
        beginType = st.trigger[tfc_pkg::TFC_TRG_BEGIN] || trig.eventOnlyMode;
        // An opcode trigger is dropped when an interrupt pends in the same cycle.
        trigQualified = trig.triggerHit && !(st.trigger[tfc_pkg::TFC_TRG_OPCODE] && core.intPending);
        // Destination address, or branch source recovered from the last cycle.
        cofAddr = core.cof[1] ? core.addr : (st.prevAddr - tfc_pkg::TFC_BRANCH_BACKSTEP);
        storeWord = trig.eventOnlyMode ? {tfc_pkg::TFC_EVENT_HIGH, core.data} : cofAddr;
    end

    // Store and disarm decisions for the current cycle.
    always_comb begin
        doStore = 1'b0;
        disarmNow = 1'b0;
        if (armedNow && beginType) begin
            // Nothing is stored before the trigger; the trigger cycle itself counts.
            if (st.triggered || trigQualified) begin
                doStore = trig.eventOnlyMode ? trigQualified : (|core.cof);
            end
            // Last of eight words ends the run.
            disarmNow = doStore && (st.validCount == tfc_pkg::TFC_FULL_COUNT - 4'h1);
        end else if (armedNow) begin
            // End runs store continuously until the trigger.
            if (trigQualified) begin
                disarmNow = 1'b1;
                // A trigger landing on a change-of-flow is kept, unless it is the interrupt's.
                doStore = (|core.cof) && !trig.eventOnlyMode && !core.intPending;
            end else begin
                doStore = |core.cof;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic.
    always_comb begin
        next_st = st;
        next_st.prevAddr = core.addr;
        next_st.breakReq = 1'b0;
        next_st.readData = 8'h00;

        if (rst) begin
            if (!powerOnReset && enabled && !st.trigger[tfc_pkg::TFC_TRG_BEGIN]) begin
                // Ending an end run: stop it but keep the results for readout.
                next_st.control[tfc_pkg::TFC_CTL_ARM] = 1'b0;
                next_st.control[tfc_pkg::TFC_CTL_BREAK] = 1'b0;
                next_st.status[tfc_pkg::TFC_STS_ARMED] = 1'b0;
                next_st.triggered = 1'b0;
            end else begin
                // Default begin run that starts at the reset vector fetch.
                next_st.mem = '0;
                next_st.wrPtr = 3'h0;
                next_st.rdPtr = 3'h0;
                next_st.validCount = 4'h0;
                next_st.cmpA.ext = tfc_pkg::TFC_RST_CMPA_EXT;
                next_st.cmpA.high = tfc_pkg::TFC_RST_CMPA_HIGH;
                next_st.cmpA.low = tfc_pkg::TFC_RST_CMPA_LOW;
                next_st.control = tfc_pkg::TFC_RST_CONTROL;
                next_st.trigger = tfc_pkg::TFC_RST_TRIGGER;
                next_st.status = tfc_pkg::TFC_RST_STATUS;
                next_st.triggered = 1'b0;
            end
        end else begin
            // Capture into the circular store.
            if (armedNow) begin
                next_st.triggered = st.triggered || (beginType && trigQualified);
            end
            if (doStore) begin
                next_st.mem[st.wrPtr] = storeWord;
                next_st.wrPtr = tfc_ptr_next(st.wrPtr);
                if (st.validCount == tfc_pkg::TFC_FULL_COUNT) begin
                    // End runs drop the oldest word once the store is full.
                    next_st.rdPtr = tfc_ptr_next(st.rdPtr);
                end else begin
                    next_st.validCount = st.validCount + 4'h1;
                end
            end
            if (disarmNow) begin
                next_st.control[tfc_pkg::TFC_CTL_ARM] = 1'b0;
                next_st.status[tfc_pkg::TFC_STS_ARMED] = 1'b0;
                next_st.breakReq = st.control[tfc_pkg::TFC_CTL_BREAK];
            end

            // Register reads; the answer stands in the following cycle.
            if (bus.rd) begin
                case (bus.addr)
                    tfc_pkg::TFC_OFF_CONTROL: begin
                        next_st.readData = st.control;
                    end
                    tfc_pkg::TFC_OFF_TRIGGER: begin
                        next_st.readData = st.trigger;
                    end
                    tfc_pkg::TFC_OFF_STATUS: begin
                        next_st.readData = st.status;
                    end
                    tfc_pkg::TFC_OFF_COUNT: begin
                        next_st.readData = {4'h0, st.validCount};
                    end
                    tfc_pkg::TFC_OFF_TRACE_HIGH: begin
                        // High half is optional and never moves the store.
                        if (enabled) begin
                            next_st.readData = tfc_oldest_byte(st, 1'b1);
                        end
                    end
                    tfc_pkg::TFC_OFF_TRACE_LOW: begin
                        if (enabled) begin
                            // Oldest word first; an armed read leaves the store alone.
                            next_st.readData = tfc_oldest_byte(st, 1'b0);
                        end
                        if (enabled && !armBit) begin
                            // Advance without touching the count.
                            next_st.rdPtr = tfc_ptr_next(st.rdPtr);
                            // Profiling: the slot at the write pointer takes the current opcode address.
                            next_st.mem[st.wrPtr] = core.opcodeAddr;
                            next_st.wrPtr = tfc_ptr_next(st.wrPtr);
                        end
                    end
                    tfc_pkg::TFC_OFF_CMPA_EXT: begin
                        next_st.readData = st.cmpA.ext;
                    end
                    tfc_pkg::TFC_OFF_CMPA_HIGH: begin
                        next_st.readData = st.cmpA.high;
                    end
                    tfc_pkg::TFC_OFF_CMPA_LOW: begin
                        next_st.readData = st.cmpA.low;
                    end
                    default: begin
                        next_st.readData = 8'h00;
                    end
                endcase
            end

            // Register writes; status, count and trace halves are read-only.
            if (bus.wr) begin
                case (bus.addr)
                    tfc_pkg::TFC_OFF_CONTROL: begin
                        next_st.control = bus.wdata;
                        if (bus.wdata[tfc_pkg::TFC_CTL_ARM] && bus.wdata[tfc_pkg::TFC_CTL_ENABLE] && !armBit) begin
                            // Arming starts a fresh run.
                            next_st.status[tfc_pkg::TFC_STS_MATCH_A] = 1'b0;
                            next_st.status[tfc_pkg::TFC_STS_MATCH_B] = 1'b0;
                            next_st.status[tfc_pkg::TFC_STS_MATCH_C] = 1'b0;
                            next_st.status[tfc_pkg::TFC_STS_ARMED] = 1'b1;
                            next_st.wrPtr = 3'h0;
                            next_st.rdPtr = 3'h0;
                            next_st.validCount = 4'h0;
                            next_st.triggered = 1'b0;
                        end
                        if (!bus.wdata[tfc_pkg::TFC_CTL_ARM]) begin
                            next_st.status[tfc_pkg::TFC_STS_ARMED] = 1'b0;
                        end
                    end
                    tfc_pkg::TFC_OFF_TRIGGER: begin
                        next_st.trigger = bus.wdata;
                    end
                    tfc_pkg::TFC_OFF_CMPA_EXT: begin
                        next_st.cmpA.ext = bus.wdata;
                    end
                    tfc_pkg::TFC_OFF_CMPA_HIGH: begin
                        next_st.cmpA.high = bus.wdata;
                    end
                    tfc_pkg::TFC_OFF_CMPA_LOW: begin
                        next_st.cmpA.low = bus.wdata;
                    end
                    default: begin
                        next_st.control = next_st.control;
                    end
                endcase
            end

            // Match flags are set only while armed; a match in the arming cycle is lost, as the arm bit is still clear then.
            if (armedNow && trig.matchA) begin
                next_st.status[tfc_pkg::TFC_STS_MATCH_A] = 1'b1;
            end
            if (armedNow && trig.matchB) begin
                next_st.status[tfc_pkg::TFC_STS_MATCH_B] = 1'b1;
            end
            if (armedNow && trig.matchC) begin
                next_st.status[tfc_pkg::TFC_STS_MATCH_C] = 1'b1;
            end

            // The armed flag cannot survive a disabled module.
            if (!next_st.control[tfc_pkg::TFC_CTL_ENABLE]) begin
                next_st.status[tfc_pkg::TFC_STS_ARMED] = 1'b0;
            end
        end
    end

    // State register.
    always_ff @(posedge clk) begin
        st <= next_st;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs.

    // Break only halts the core; this block has no reset request at all.
    assign breakRequest = st.breakReq;
    assign readData = st.readData;
    assign cmpA = st.cmpA;
    assign triggerReg = st.trigger;
    assign controlReg = st.control;
    assign armed = st.status[tfc_pkg::TFC_STS_ARMED];

endmodule

// ===== test/tfc_trace_capture_assertions.sv
// Checker for the trace capture block, watching only its top-level ports.
// Assumes the bind at the foot of this file attaches it to every instance.
`timescale 1ns/10ps

module tfc_trace_capture_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic powerOnReset,
    input wire tfc_pkg::tfc_bus_t bus,
    input wire logic [7:0] readData,
    input wire tfc_pkg::tfc_core_t core,
    input wire tfc_pkg::tfc_trig_t trig,
    input wire tfc_pkg::tfc_cmpa_t cmpA,
    input wire logic [7:0] triggerReg,
    input wire logic [7:0] controlReg,
    input wire logic armed,
    input wire logic breakRequest
);
    ////////////////////////////////////////////////////////////////////////////
    // Read answers stand only in the cycle after a read strobe.
    property p_readIdle;
        @(posedge clk) disable iff (rst) !$past(bus.rd) |-> readData == 8'h00;
    endproperty
    a_readIdle: assert property (p_readIdle) else $error("read data outside answer cycle");
    property p_readDisabled;
        @(posedge clk) disable iff (rst)
        bus.rd && bus.addr inside {4'h4, 4'h5} && !controlReg[7] |=> readData == 8'h00;
    endproperty
    a_readDisabled: assert property (p_readDisabled) else $error("trace read while disabled");

    ////////////////////////////////////////////////////////////////////////////
    // Default reset loads comparator A and the control and trigger registers.
    property p_resetCmpA;
        @(posedge clk) rst && powerOnReset |=> cmpA == {8'h00, 8'hff, 8'hfe};
    endproperty
    a_resetCmpA: assert property (p_resetCmpA) else $error("comparator A reset value");
    property p_resetCtl;
        @(posedge clk) rst && powerOnReset |=> controlReg == 8'hc0 && triggerReg == 8'h40 && armed;
    endproperty
    a_resetCtl: assert property (p_resetCtl) else $error("control or trigger reset value");
    property p_endRunReset;
        @(posedge clk) rst && !powerOnReset && controlReg[7] && !triggerReg[6]
        |=> !armed && !controlReg[6] && !controlReg[4];
    endproperty
    a_endRunReset: assert property (p_endRunReset) else $error("end run reset kept arm");

    ////////////////////////////////////////////////////////////////////////////
    // Arming, disarming on the end trigger, and the break pulse.
    property p_armWrite;
        @(posedge clk) disable iff (rst)
        bus.wr && bus.addr == 4'h0 && bus.wdata[7:6] == 2'b11 && !controlReg[6] |=> armed;
    endproperty
    a_armWrite: assert property (p_armWrite) else $error("arming write did not arm");
    property p_endTrigDisarm;
        @(posedge clk) disable iff (rst)
        armed && !triggerReg[6] && !trig.eventOnlyMode && trig.triggerHit
        && !(triggerReg[7] && core.intPending) && !bus.wr |=> !armed && !controlReg[6];
    endproperty
    a_endTrigDisarm: assert property (p_endTrigDisarm) else $error("end trigger did not disarm");
    property p_opcodeInt;
        @(posedge clk) disable iff (rst)
        armed && !triggerReg[6] && triggerReg[7] && trig.triggerHit && core.intPending && !bus.wr |=> armed;
    endproperty
    a_opcodeInt: assert property (p_opcodeInt) else $error("opcode trigger taken with interrupt");
    property p_breakPulse;
        @(posedge clk) disable iff (rst) breakRequest |-> !armed ##1 !breakRequest;
    endproperty
    a_breakPulse: assert property (p_breakPulse) else $error("break request not a run-end pulse");
endmodule

bind tfc_trace_capture tfc_trace_capture_checker u_checker (
    .clk(clk), .rst(rst), .powerOnReset(powerOnReset), .bus(bus), .readData(readData), .core(core),
    .trig(trig), .cmpA(cmpA), .triggerReg(triggerReg), .controlReg(controlReg), .armed(armed),
    .breakRequest(breakRequest)
);

// ===== test/tfc_core_model.sv
// Model of the CPU core and trigger decode feeding the trace capture block.
// Assumes the bench calls put right after a rising clock edge.
`timescale 1ns/10ps

module tfc_core_model (
    input wire logic clk,
    input wire logic [7:0] triggerReg,
    output tfc_pkg::tfc_core_t core,
    output tfc_pkg::tfc_trig_t trig
);
    logic [1:0] cof = 2'b00;
    logic [15:0] addr = 16'h0000;
    logic [7:0] data = 8'h00;
    logic hit = 1'b0;
    logic intp = 1'b0;
    logic evReq = 1'b0;
    logic [15:0] opc = 16'h8000;

    ////////////////////////////////////////////////////////////////////////////
    // The opcode address moves every cycle, as a running program would.
    always @(posedge clk) begin
        opc <= opc + 16'h0003;
    end

    // Event-only mode is never offered together with end-trigger storage.
    // Every comparator reports a match on a hit, so all three flags get exercised.
    assign core = '{cof, addr, data, opc, intp};
    assign trig = '{hit, evReq && triggerReg[6], hit, hit, hit};

    // Presents one cycle of core activity.
    task automatic put(input logic [1:0] c, input logic [15:0] a, input logic [7:0] d,
                       input logic h, input logic ip, input logic ev);
        cof <= c;
        addr <= a;
        data <= d;
        hit <= h;
        intp <= ip;
        evReq <= ev;
    endtask
endmodule

// ===== test/testbench.sv
// Self-checking bench for the trace capture block: capture runs, readout,
// profiling and both kinds of reset. Assumes the core model and the checker.
`timescale 1ns/10ps
`define CHK(g, w) begin n_tests++; if ((g) !== (w)) begin n_errors++; $display("MISMATCH %0t got %h want %h", $time, g, w); end end

module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic powerOnReset = 1'b1;
    tfc_pkg::tfc_bus_t bus = '0;
    logic [7:0] readData;
    tfc_pkg::tfc_core_t core;
    tfc_pkg::tfc_trig_t trig;
    tfc_pkg::tfc_cmpa_t cmpA;
    logic [7:0] triggerReg;
    logic [7:0] controlReg;
    logic armed;
    logic breakRequest;
    int n_errors = 0;
    int n_tests = 0;
    logic [15:0] q[$];
    logic [15:0] prof[$];
    logic [15:0] prevAddr = 16'h0000;
    logic [3:0] nValid = 4'h0;
    int nBreak = 0;
    logic [7:0] rd;
    logic [15:0] lastOp;

    ////////////////////////////////////////////////////////////////////////////
    // Clock at 10 MHz.
    initial begin
        forever #50 clk = ~clk;
    end

    tfc_trace_capture dut (.clk(clk), .rst(rst), .powerOnReset(powerOnReset), .bus(bus), .readData(readData),
        .core(core), .trig(trig), .cmpA(cmpA), .triggerReg(triggerReg), .controlReg(controlReg),
        .armed(armed), .breakRequest(breakRequest));
    tfc_core_model model (.clk(clk), .triggerReg(triggerReg), .core(core), .trig(trig));

    // Counts the cycles in which a break request stands.
    always @(posedge clk) begin
        if (breakRequest === 1'b1) nBreak++;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register port cycles; a read also notes the opcode address it samples.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask

    task automatic rdReg(input logic [3:0] a);
        @(posedge clk);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        #1 lastOp = core.opcodeAddr;
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 rd = readData;
    endtask

    // Stored address for a change of flow: destination, or branch source.
    function automatic logic [15:0] source(input logic [1:0] c, input logic [15:0] a, input logic [15:0] p);
        return c[1] ? a : p - tfc_pkg::TFC_BRANCH_BACKSTEP;
    endfunction

    // Adds an expected entry; the oldest falls out past eight.
    task automatic keep(input logic [15:0] v);
        q.push_back(v);
        if (q.size() > 8) void'(q.pop_front());
        if (nValid != tfc_pkg::TFC_FULL_COUNT) nValid++;
    endtask

    // Drives n random core cycles and predicts what the store keeps.
    task automatic run(input int n, input int hitAt, input int fakeAt, input bit beg, input bit ev,
                       input bit intAtHit, input bit opSel, input int rdAt);
        logic [1:0] c;
        logic [15:0] a;
        logic [7:0] d;
        logic h;
        logic ip;
        logic [15:0] old;
        bit on;
        bit live;
        live = 1;
        on = 0;
        q.delete();
        nValid = 4'h0;
        for (int i = 0; i < n; i++) begin
            c = (i == 0 || i == hitAt) ? 2'b01 : 2'($urandom);
            a = 16'($urandom);
            d = 8'($urandom);
            h = (i == hitAt || i == fakeAt || (ev && i > hitAt && $urandom % 2 == 1));
            ip = (i == fakeAt) || (i == hitAt && intAtHit);
            @(posedge clk);
            model.put(c, a, d, h, ip, ev);
            if (i == rdAt) begin
                bus <= '{tfc_pkg::TFC_OFF_TRACE_LOW, 8'h00, 1'b0, 1'b1};
                old = q[0];
            end
            if (i == rdAt + 1) begin
                bus.rd <= 1'b0;
                #1 `CHK(readData, old[7:0])
            end
            h = h && !(opSel && ip);
            if (live && ev && h) keep({tfc_pkg::TFC_EVENT_HIGH, d});
            else if (live && !ev && (on || h || !beg) && c != 2'b00 && !(h && ip && !beg))
                keep(source(c, a, prevAddr));
            on = on || h;
            if ((!beg && h) || (beg && q.size() == 8)) live = 0;
            prevAddr = a;
        end
        @(posedge clk);
        model.put(2'b00, a, 8'h00, 1'b0, 1'b0, ev);
        repeat (2) @(posedge clk);
        `CHK(armed, 1'(live))
        `CHK(controlReg[6], 1'(live))
    endtask

    // Reads the count and every expected word, oldest first.
    task automatic drain(input bit ev);
        rdReg(tfc_pkg::TFC_OFF_COUNT);
        `CHK(rd, {4'h0, nValid})
        prof.delete();
        foreach (q[k]) begin
            if (!ev || k == 0) begin
                rdReg(tfc_pkg::TFC_OFF_TRACE_HIGH);
                `CHK(rd, q[k][15:8])
            end
            rdReg(tfc_pkg::TFC_OFF_TRACE_LOW);
            prof.push_back(lastOp);
            `CHK(rd, q[k][7:0])
        end
        rdReg(tfc_pkg::TFC_OFF_COUNT);
        `CHK(rd, {4'h0, nValid})
    endtask

    // Checks the values a default reset loads.
    task automatic defaults();
        logic [7:0] want [6] = '{8'hc0, 8'h40, 8'h01, 8'h00, 8'hff, 8'hfe};
        logic [3:0] at [6] = '{4'h0, 4'h1, 4'h2, 4'h6, 4'h7, 4'h8};
        for (int k = 0; k < 6; k++) begin
            rdReg(at[k]);
            `CHK(rd, want[k])
        end
    endtask

    task automatic pulseReset();
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence: default begin run, event-only, three end runs, resets.
    initial begin
        void'($urandom(31188));
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        powerOnReset <= 1'b0;
        defaults();
        run(30, 4, -1, 1, 0, 1, 0, 99);
        drain(0);
        if (q.size() == 8) begin
            rdReg(tfc_pkg::TFC_OFF_TRACE_HIGH);
            `CHK(rd, prof[0][15:8])
            rdReg(tfc_pkg::TFC_OFF_TRACE_LOW);
            `CHK(rd, prof[0][7:0])
        end
        wr(4'h1, 8'h40);
        wr(4'h0, 8'hc0);
        run(30, 3, -1, 1, 1, 0, 0, 99);
        drain(1);
        rdReg(tfc_pkg::TFC_OFF_STATUS);
        `CHK(rd, 8'he0)
        wr(4'h1, 8'h80);
        wr(4'h0, 8'hd0);
        rdReg(tfc_pkg::TFC_OFF_STATUS);
        `CHK(rd, 8'h01)
        run(24, 16, 5, 0, 0, 0, 1, 6);
        drain(0);
        wr(4'h1, 8'h00);
        wr(4'h0, 8'hd0);
        run(16, 9, -1, 0, 0, 1, 0, 99);
        drain(0);
        wr(4'h0, 8'hd0);
        run(12, 99, -1, 0, 0, 0, 0, 99);
        pulseReset();
        @(posedge clk);
        #1 `CHK(controlReg, 8'h80)
        drain(0);
        wr(tfc_pkg::TFC_OFF_CMPA_LOW, 8'h5a);
        rdReg(tfc_pkg::TFC_OFF_CMPA_LOW);
        `CHK(rd, 8'h5a)
        wr(4'h1, 8'h40);
        pulseReset();
        defaults();
        wr(4'h0, 8'h00);
        rdReg(tfc_pkg::TFC_OFF_TRACE_LOW);
        `CHK(rd, 8'h00)
        rdReg(4'hf);
        `CHK(rd, 8'h00)
        `CHK(nBreak, 2)
        give_verdict();
    end

    // Cuts a hung run short.
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        give_verdict();
    end
endmodule
